// *** rtl/ssw_pkg.sv ***
// Purpose: shared constants for the serial slave with watchdog control
// Assumes: 40 MHz system clock, 8-bit serial registers, 5-bit addresses
// Notes:   all offsets, field positions, reset values and counts live here
package ssw_pkg;
    // register addresses
    localparam logic [4:0] ADDR_WDOG  = 5'h00;
    localparam logic [4:0] ADDR_CTRL0 = 5'h01;
    localparam logic [4:0] ADDR_CTRL1 = 5'h02;
    localparam logic [4:0] ADDR_CTRL2 = 5'h03;
    localparam logic [4:0] ADDR_STAT0 = 5'h04;
    // field positions
    localparam int WD_EN_BIT    = 7;
    localparam int WD_SEL_MSB   = 6;
    localparam int WD_SEL_LSB   = 3;
    localparam int SLEEP_BIT    = 6;
    localparam int STAT_PAR_BIT = 7;
    localparam int CMD_OP_BIT   = 7;
    // reset values
    localparam logic [7:0] REG_RESET = 8'h00;
    // packet geometry
    localparam logic [4:0] PACKET_BITS = 5'h10;
    localparam logic [2:0] LAST_BIT    = 3'h7;
    // clock and timing
    localparam int CLK_HZ          = 40_000_000;
    localparam int CLK_NS          = 25;
    localparam int TICK_MS         = 1;
    localparam int TICK_CYC        = CLK_HZ / 1000 * TICK_MS;
    localparam int TIMEOUT_STEP_MS = 32;
    localparam int TIMEOUT_MAX_MS  = 512;
    localparam int HARD_MIN_NS     = 1000;
    localparam int HARD_MIN_CYC    = (HARD_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int EARLY_MS        = 4;
    localparam int PULSE_MS        = 2;
    // serial byte phase
    typedef enum logic {SSW_CMD, SSW_DATA} ssw_phase_t;
    // watchdog states
    typedef enum logic [1:0] {WD_IDLE, WD_RUN, WD_FIRE} ssw_wd_state_t;
endpackage

// *** rtl/ssw_wdog_if.sv ***
// Purpose: carrier between serial front end and watchdog timer
// Assumes: all signals on the system clock
// Notes:   kick and disarm are one-cycle pulses on a committed write
`timescale 1ns/1ps
interface ssw_wdog_if;
    logic       tick;      // one millisecond enable
    logic       sleep;     // freezes the count
    logic       kick;      // enable written as one
    logic       disarm;    // enable written as zero
    logic [3:0] sel;       // timeout select
    logic       fire;      // pulse when the dog bites
    logic       reset_act; // host reset pulse level
    modport ctl (output tick, sleep, kick, disarm, sel,
                 input fire, reset_act);
    modport dog (input tick, sleep, kick, disarm, sel,
                 output fire, reset_act);
endinterface

// *** rtl/ssw_wdog.sv ***
// Purpose: watchdog timer counting millisecond ticks
// Assumes: synchronous active-high reset already merged with hard reset
// Notes:   count is in ms; timeout is 32 ms per select step plus one
`timescale 1ns/1ps
module ssw_wdog #(
    parameter int EARLY_LIM_MS = ssw_pkg::EARLY_MS,
    parameter int PULSE_LEN_MS = ssw_pkg::PULSE_MS
) (
    // clock and reset
    input  wire logic i_clk_sys,
    input  wire logic i_rst,
    // control side
    ssw_wdog_if.dog   wd
);
    import ssw_pkg::*;

    localparam logic [9:0] EARLY_LIM = 10'(EARLY_LIM_MS);
    localparam logic [9:0] PULSE_LEN = 10'(PULSE_LEN_MS);
    localparam logic [9:0] STEP_MS   = 10'(TIMEOUT_STEP_MS);

    ssw_wd_state_t state_reg, state_next; // timer state
    logic [9:0]    cnt_reg, cnt_next;     // elapsed ms
    logic [9:0]    limit;                 // timeout in ms
    logic          fire_c;

    // timeout table: (sel + 1) * 32 ms, 32 up to 512
    assign limit = 10'(({6'h00, wd.sel} + 10'h001) * STEP_MS);

    // next-state of the timer
    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        fire_c     = 1'b0;
        case (state_reg)
            WD_IDLE: begin
                if (wd.kick) begin
                    state_next = WD_RUN;
                    cnt_next   = 10'h000;
                end
            end
            WD_RUN: begin
                if (wd.disarm) begin
                    state_next = WD_IDLE;
                    cnt_next   = 10'h000;
                end else if (wd.kick) begin
                    cnt_next = 10'h000;
                    // too early a kick bites as hard as a missed one
                    if (cnt_reg < EARLY_LIM) begin
                        state_next = WD_FIRE;
                        fire_c     = 1'b1;
                    end
                end else if (wd.tick && !wd.sleep) begin
                    if (cnt_reg + 10'h001 >= limit) begin
                        state_next = WD_FIRE;
                        cnt_next   = 10'h000;
                        fire_c     = 1'b1;
                    end else begin
                        cnt_next = cnt_reg + 10'h001;
                    end
                end
            end
            default: begin
                // reset pulse length in ticks; host must re-enable after
                if (wd.tick) begin
                    if (cnt_reg + 10'h001 >= PULSE_LEN) begin
                        state_next = WD_IDLE;
                        cnt_next   = 10'h000;
                    end else begin
                        cnt_next = cnt_reg + 10'h001;
                    end
                end
            end
        endcase
    end

    // timer registers
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            state_reg <= WD_IDLE;
            cnt_reg   <= 10'h000;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
        end
    end

    assign wd.fire      = fire_c;
    assign wd.reset_act = (state_reg == WD_FIRE);

    a_dog_starts: assert property (
        @(posedge i_clk_sys) disable iff (i_rst)
        (state_reg == WD_IDLE && wd.kick)
        |=> (state_reg == WD_RUN && cnt_reg == 10'h000))
        else $error("watchdog did not start on enable");
    a_dog_timeout: assert property (
        @(posedge i_clk_sys) disable iff (i_rst)
        (state_reg == WD_RUN && !wd.kick && !wd.disarm && wd.tick
         && !wd.sleep && cnt_reg + 10'h001 == limit)
        |=> wd.reset_act)
        else $error("watchdog missed its timeout");
    a_dog_early: assert property (
        @(posedge i_clk_sys) disable iff (i_rst)
        (state_reg == WD_RUN && !wd.disarm && wd.kick
         && cnt_reg < EARLY_LIM) |=> wd.reset_act)
        else $error("early kick did not bite");
    a_dog_sleep: assert property (
        @(posedge i_clk_sys) disable iff (i_rst)
        (state_reg == WD_RUN && wd.sleep && !wd.kick && !wd.disarm)
        |=> $stable(cnt_reg))
        else $error("watchdog counted during sleep");
endmodule

// *** rtl/ssw_top.sv ***
// Purpose: serial register slave with watchdog, hard reset and sleep
// Assumes: serial pins asynchronous, sampled by 40 MHz system clock
// Notes:   serial clock period must exceed about six system clocks
// Summary of operation
// - enable write starts or restarts watchdog count
// - early or missing kick pulses host reset
// - watchdog bite sets warm boot flag
// - enable written zero clears warm boot flag
// - timeout is 32 ms times select plus one
// - held hard reset clears all registers but the pin synchronisers
// - hard reset disarms watchdog, no host reset
// - sleep floats drivers, keeps registers and serial
// - watchdog count freezes during sleep
// - sleep ends on zero write, host waits
// - slave only; output floats when unselected
// - out on falling, in on rising edge
// - msb first; command then data byte
// - top command bit: zero read, one write
// - read-only writes ignored; read followed by command
// - status bit seven is even parity
// - write commits at select rise, sixteen clocks
// - select rise after status read clears latches
// - status and fault refresh only when deselected
// - output buffer loads last address each byte
// - sleep bit is bit six at 03h
`timescale 1ns/1ps
module ssw_top #(
    parameter int TICK_CYCLES  = ssw_pkg::TICK_CYC,
    parameter int EARLY_LIM_MS = ssw_pkg::EARLY_MS,
    parameter int PULSE_LEN_MS = ssw_pkg::PULSE_MS
) (
    // clock and reset
    input  wire logic       i_clk_sys,
    input  wire logic       i_nrst,
    // serial link
    input  wire logic       i_select_n,
    input  wire logic       i_sck,
    input  wire logic       i_serial_in,
    output wire logic       o_serial_out,
    output wire logic       o_serial_out_oe,
    // hard reset pin
    input  wire logic       i_hard_reset_in,
    // open-drain host reset
    output wire logic       o_host_reset_out_n,
    output wire logic       o_host_reset_oe,
    // fault status
    input  wire logic [5:0] i_fault_flags,
    output wire logic       o_fault_out_n,
    // control outputs
    output wire logic [7:0] o_step_ctrl,
    output wire logic [7:0] o_drive_ctrl,
    output wire logic [7:0] o_motor_ctrl,
    output wire logic       o_drivers_hiz
);
    import ssw_pkg::*;

    localparam int TICK_W = $clog2(TICK_CYCLES + 1);
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);
    localparam logic [7:0] HARD_CNT = 8'(HARD_MIN_CYC);

    ssw_wdog_if wd ();

    // pin synchronisers: stage 1 read only by stage 2
    logic [1:0] sck_s_reg, sck_s_next;
    logic [1:0] sel_s_reg, sel_s_next;
    logic [1:0] din_s_reg, din_s_next;
    logic [1:0] hr_s_reg, hr_s_next;
    logic       sck_p_reg, sck_p_next;   // delayed clock for edges
    logic       sel_p_reg, sel_p_next;   // delayed select for edges
    logic [7:0] hr_cnt_reg, hr_cnt_next; // hard reset hold count
    logic       hard_reg, hard_next;     // hard reset in force
    logic       sys_rst;                 // merged internal reset
    logic       sck_rise, sck_fall, sel_rise, sel_high;

    // serial engine
    ssw_phase_t phase_reg, phase_next;
    logic [4:0] bit_cnt_reg, bit_cnt_next;   // rising edges, saturating
    logic [2:0] fall_cnt_reg, fall_cnt_next; // falling edges in byte
    logic [7:0] rx_reg, rx_next;             // input shifter
    logic [7:0] tx_reg, tx_next;             // output shift buffer
    logic [4:0] addr_reg, addr_next;         // last address received
    logic       wr_op_reg, wr_op_next;       // packet is a write
    logic [7:0] wr_dat_reg, wr_dat_next;     // pending write data
    logic       clr_arm_reg, clr_arm_next;   // status read just ended
    logic [7:0] rx_byte, rd_data;
    logic       byte_done, commit, clear_lat;

    // register bank and status
    logic [7:0] wdog_reg, wdog_next;
    logic [7:0] ctrl0_reg, ctrl0_next;
    logic [7:0] ctrl1_reg, ctrl1_next;
    logic [7:0] ctrl2_reg, ctrl2_next;
    logic       warm_reg, warm_next;     // warm boot flag
    logic [5:0] lat_reg, lat_next;       // latched faults
    logic       fault_n_reg, fault_n_next;
    logic [TICK_W-1:0] tick_reg, tick_next; // ms divider
    logic [6:0] stat_low;

    // synchroniser and hard reset qualification
    always_comb begin
        sck_s_next  = {sck_s_reg[0], i_sck};
        sel_s_next  = {sel_s_reg[0], i_select_n};
        din_s_next  = {din_s_reg[0], i_serial_in};
        hr_s_next   = {hr_s_reg[0], i_hard_reset_in};
        sck_p_next  = sck_s_reg[1];
        sel_p_next  = sel_s_reg[1];
        hr_cnt_next = 8'h00;
        hard_next   = 1'b0;
        // reset only after the pin has stood high its least time
        if (hr_s_reg[1]) begin
            hard_next   = hard_reg || (hr_cnt_reg >= HARD_CNT - 8'h01);
            hr_cnt_next = (hr_cnt_reg == 8'hff) ? hr_cnt_reg
                          : hr_cnt_reg + 8'h01;
        end
    end

    // synchroniser registers
    always_ff @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            sck_s_reg  <= 2'h0;
            sel_s_reg  <= 2'h3;
            din_s_reg  <= 2'h0;
            hr_s_reg   <= 2'h0;
            sck_p_reg  <= 1'b0;
            sel_p_reg  <= 1'b1;
            hr_cnt_reg <= 8'h00;
            hard_reg   <= 1'b0;
        end else begin
            sck_s_reg  <= sck_s_next;
            sel_s_reg  <= sel_s_next;
            din_s_reg  <= din_s_next;
            hr_s_reg   <= hr_s_next;
            sck_p_reg  <= sck_p_next;
            sel_p_reg  <= sel_p_next;
            hr_cnt_reg <= hr_cnt_next;
            hard_reg   <= hard_next;
        end
    end

    assign sys_rst  = !i_nrst || hard_reg;
    assign sel_high = sel_s_reg[1];
    assign sck_rise = !sel_high && sck_s_reg[1] && !sck_p_reg;
    assign sck_fall = !sel_high && !sck_s_reg[1] && sck_p_reg;
    assign sel_rise = sel_high && !sel_p_reg;
    assign rx_byte  = {rx_reg[6:0], din_s_reg[1]};
    assign byte_done = sck_rise && (bit_cnt_reg[2:0] == LAST_BIT);
    assign commit   = sel_rise && wr_op_reg
                      && (bit_cnt_reg == PACKET_BITS);
    assign clear_lat = sel_rise && clr_arm_reg;

    // read mux; parity over the low seven status bits
    assign stat_low = {warm_reg, lat_reg};
    always_comb begin
        if (addr_reg == ADDR_WDOG) begin
            rd_data = wdog_reg;
        end else if (addr_reg == ADDR_CTRL0) begin
            rd_data = ctrl0_reg;
        end else if (addr_reg == ADDR_CTRL1) begin
            rd_data = ctrl1_reg;
        end else if (addr_reg == ADDR_CTRL2) begin
            rd_data = ctrl2_reg;
        end else if (addr_reg == ADDR_STAT0) begin
            rd_data = {^stat_low, stat_low};
        end else begin
            rd_data = 8'h00;
        end
    end

    // serial engine next values
    always_comb begin
        phase_next    = phase_reg;
        bit_cnt_next  = bit_cnt_reg;
        fall_cnt_next = fall_cnt_reg;
        rx_next       = rx_reg;
        tx_next       = tx_reg;
        addr_next     = addr_reg;
        wr_op_next    = wr_op_reg;
        wr_dat_next   = wr_dat_reg;
        clr_arm_next  = clr_arm_reg;
        if (sel_high) begin
            // a new packet always opens with a command byte
            phase_next    = SSW_CMD;
            bit_cnt_next  = 5'h00;
            fall_cnt_next = 3'h0;
            wr_op_next    = 1'b0;
            clr_arm_next  = 1'b0;
        end else begin
            if (sck_rise) begin
                rx_next = rx_byte;
                if (bit_cnt_reg != 5'h1f) begin
                    bit_cnt_next = bit_cnt_reg + 5'h01;
                end
            end
            if (byte_done) begin
                clr_arm_next = 1'b0;
                if (phase_reg == SSW_CMD) begin
                    addr_next = rx_byte[4:0];
                    if (rx_byte[CMD_OP_BIT]) begin
                        wr_op_next = 1'b1;
                        phase_next = SSW_DATA;
                    end else begin
                        // any later byte is decoded afresh
                        clr_arm_next = (rx_byte[4:0] == ADDR_STAT0);
                    end
                end else begin
                    wr_dat_next = rx_byte;
                    phase_next  = SSW_CMD;
                end
            end
            if (sck_fall) begin
                fall_cnt_next = fall_cnt_reg + 3'h1;
                // late load: first byte of a packet may show stale data
                if (fall_cnt_reg == LAST_BIT) begin
                    tx_next = rd_data;
                end else begin
                    tx_next = {tx_reg[6:0], 1'b0};
                end
            end
        end
    end

    // serial engine registers; address left as reset value
    always_ff @(posedge i_clk_sys) begin
        if (sys_rst) begin
            phase_reg    <= SSW_CMD;
            bit_cnt_reg  <= 5'h00;
            fall_cnt_reg <= 3'h0;
            rx_reg       <= REG_RESET;
            tx_reg       <= REG_RESET;
            addr_reg     <= ADDR_WDOG;
            wr_op_reg    <= 1'b0;
            wr_dat_reg   <= REG_RESET;
            clr_arm_reg  <= 1'b0;
        end else begin
            phase_reg    <= phase_next;
            bit_cnt_reg  <= bit_cnt_next;
            fall_cnt_reg <= fall_cnt_next;
            rx_reg       <= rx_next;
            tx_reg       <= tx_next;
            addr_reg     <= addr_next;
            wr_op_reg    <= wr_op_next;
            wr_dat_reg   <= wr_dat_next;
            clr_arm_reg  <= clr_arm_next;
        end
    end

    // register bank, status latches and ms divider
    always_comb begin
        wdog_next    = wdog_reg;
        ctrl0_next   = ctrl0_reg;
        ctrl1_next   = ctrl1_reg;
        ctrl2_next   = ctrl2_reg;
        warm_next    = warm_reg;
        lat_next     = lat_reg;
        fault_n_next = fault_n_reg;
        tick_next    = tick_reg;
        // divider stops in sleep, as the core clocks do
        if (!ctrl2_reg[SLEEP_BIT]) begin
            tick_next = (tick_reg == TICK_LAST) ? '0
                        : tick_reg + TICK_W'(1);
        end
        if (commit) begin
            // status address and unmapped ones are read only
            if (addr_reg == ADDR_WDOG) begin
                wdog_next = wr_dat_reg;
                if (!wr_dat_reg[WD_EN_BIT]) begin
                    warm_next = 1'b0;
                end
            end else if (addr_reg == ADDR_CTRL0) begin
                ctrl0_next = wr_dat_reg;
            end else if (addr_reg == ADDR_CTRL1) begin
                ctrl1_next = wr_dat_reg;
            end else if (addr_reg == ADDR_CTRL2) begin
                ctrl2_next = wr_dat_reg;
            end
        end
        if (clear_lat) begin
            lat_next = 6'h00;
        end
        // new events win over a clear in the same cycle
        if (sel_high) begin
            lat_next     = lat_next | i_fault_flags;
            fault_n_next = ~|lat_reg;
        end
        if (wd.fire) begin
            warm_next = 1'b1;
        end
    end

    // register bank registers
    always_ff @(posedge i_clk_sys) begin
        if (sys_rst) begin
            wdog_reg    <= REG_RESET;
            ctrl0_reg   <= REG_RESET;
            ctrl1_reg   <= REG_RESET;
            ctrl2_reg   <= REG_RESET;
            warm_reg    <= 1'b0;
            lat_reg     <= 6'h00;
            fault_n_reg <= 1'b1;
            tick_reg    <= '0;
        end else begin
            wdog_reg    <= wdog_next;
            ctrl0_reg   <= ctrl0_next;
            ctrl1_reg   <= ctrl1_next;
            ctrl2_reg   <= ctrl2_next;
            warm_reg    <= warm_next;
            lat_reg     <= lat_next;
            fault_n_reg <= fault_n_next;
            tick_reg    <= tick_next;
        end
    end

    // watchdog hookup
    assign wd.tick   = !ctrl2_reg[SLEEP_BIT] && (tick_reg == TICK_LAST);
    assign wd.sleep  = ctrl2_reg[SLEEP_BIT];
    assign wd.kick   = commit && (addr_reg == ADDR_WDOG)
                       && wr_dat_reg[WD_EN_BIT];
    assign wd.disarm = commit && (addr_reg == ADDR_WDOG)
                       && !wr_dat_reg[WD_EN_BIT];
    assign wd.sel    = wdog_reg[WD_SEL_MSB:WD_SEL_LSB];

    ssw_wdog #(
        .EARLY_LIM_MS (EARLY_LIM_MS),
        .PULSE_LEN_MS (PULSE_LEN_MS)
    ) u_wdog (
        .i_clk_sys (i_clk_sys),
        .i_rst     (sys_rst),
        .wd        (wd)
    );

    // outputs
    assign o_serial_out       = tx_reg[7];
    assign o_serial_out_oe    = !sel_high;
    assign o_host_reset_out_n = 1'b0;
    assign o_host_reset_oe    = wd.reset_act;
    assign o_fault_out_n      = fault_n_reg;
    assign o_step_ctrl        = ctrl0_reg;
    assign o_drive_ctrl       = ctrl1_reg;
    assign o_motor_ctrl       = ctrl2_reg;
    assign o_drivers_hiz      = ctrl2_reg[SLEEP_BIT];

    a_hard_clears: assert property (
        @(posedge i_clk_sys) hard_reg |=> (ctrl2_reg == REG_RESET
        && wdog_reg == REG_RESET && !warm_reg && !o_host_reset_oe))
        else $error("hard reset left state behind");
    a_short_packet: assert property (
        @(posedge i_clk_sys) disable iff (sys_rst)
        (sel_rise && bit_cnt_reg != PACKET_BITS)
        |=> $stable(wdog_reg) && $stable(ctrl0_reg) && $stable(ctrl2_reg))
        else $error("bad-length packet was committed");
    a_write_lands: assert property (
        @(posedge i_clk_sys) disable iff (sys_rst)
        (commit && addr_reg == ADDR_CTRL0) |=> ctrl0_reg == $past(wr_dat_reg))
        else $error("committed write did not land");
    a_status_hold: assert property (
        @(posedge i_clk_sys) disable iff (sys_rst)
        !sel_high |=> $stable(fault_n_reg))
        else $error("fault output moved while selected");
    a_stat_parity: assert property (
        @(posedge i_clk_sys) disable iff (sys_rst)
        (sck_fall && fall_cnt_reg == LAST_BIT && addr_reg == ADDR_STAT0)
        |=> ^tx_reg == 1'b0)
        else $error("status byte parity wrong");
    a_warm_set: assert property (
        @(posedge i_clk_sys) disable iff (sys_rst)
        wd.fire |=> warm_reg ##1 o_host_reset_oe)
        else $error("bite not recorded");
    a_out_float: assert property (
        @(posedge i_clk_sys) disable iff (sys_rst)
        $past(i_select_n, 2) |-> !o_serial_out_oe)
        else $error("serial out driven while deselected");
endmodule

// *** verification/ssw_spi_host.sv ***
// Purpose: host model that drives the serial link of the slave
// Assumes: 200 ns link clock that is stopped outside packets
// Notes:   data line is inverted on release so a stale bit never matches
`timescale 1ns/1ps
module ssw_spi_host (
    input  wire logic i_clk,
    output logic      o_select_n,
    output logic      o_sck,
    output logic      o_mosi,
    input  wire logic i_miso
);
    initial begin
        o_select_n = 1'b1;
        o_sck      = 1'b0;
        o_mosi     = 1'b0;
    end
    // one packet sent from bit 16 down, msb first; all moves on clock edges
    // link clock is 4 system clocks high and 4 low, so 200 ns a bit
    task automatic xfer(input logic [16:0] tx, input int nb,
                        output logic [15:0] rx);
        rx = '0;
        @(posedge i_clk) o_select_n <= 1'b0;
        repeat (8) @(posedge i_clk);
        for (int i = 16; i > 16 - nb; i--) begin
            o_mosi <= tx[i];
            repeat (4) @(posedge i_clk);
            o_sck <= 1'b1;
            // sample at the end of the high phase, long after the fall
            repeat (4) @(posedge i_clk);
            rx = {rx[14:0], i_miso};
            o_sck <= 1'b0;
        end
        repeat (8) @(posedge i_clk);
        o_select_n <= 1'b1;
        o_mosi     <= ~o_mosi;
        repeat (16) @(posedge i_clk);
    endtask
endmodule

// *** verification/spi_slave_watchdog_control_test.sv ***
// Purpose: self-checking bench for the serial slave with watchdog
// Assumes: tick shortened to 40 clocks, early limit of 8 ticks
// Notes:   link line read back inverted while output is disabled
`timescale 1ns/1ps
module spi_slave_watchdog_control_test;
    import ssw_pkg::*;
    logic clk = 1'b0, nrst = 1'b0, hard = 1'b0;
    logic [5:0] flt = '0;
    logic [15:0] rx;
    wire sn, sck, mosi, so, oe, hn, hoe, fn, hiz;
    wire [7:0] c1, c2, c3;
    wire miso = oe ? so : ~so;
    int error_cnt = 0, n_tests = 0, cyc = 0;
    always #12.5 clk = ~clk;
    ssw_top #(.TICK_CYCLES(40), .EARLY_LIM_MS(8)) i_ssw_top (
        .i_clk_sys(clk), .i_nrst(nrst), .i_select_n(sn), .i_sck(sck),
        .i_serial_in(mosi), .o_serial_out(so), .o_serial_out_oe(oe),
        .i_hard_reset_in(hard), .o_host_reset_out_n(hn),
        .o_host_reset_oe(hoe), .i_fault_flags(flt), .o_fault_out_n(fn),
        .o_step_ctrl(c1), .o_drive_ctrl(c2), .o_motor_ctrl(c3),
        .o_drivers_hiz(hiz));
    ssw_spi_host i_ssw_spi_host (.i_clk(clk), .o_select_n(sn),
        .o_sck(sck), .o_mosi(mosi), .i_miso(miso));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            end_of_test();
        end
    end
    // packets are left aligned: command byte first, then data
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        i_ssw_spi_host.xfer({3'h4, a, d, 1'h0}, 16, rx);
    endtask
    task automatic rd(input logic [4:0] a, input logic [7:0] e);
        i_ssw_spi_host.xfer({3'h0, a, 3'h0, a, 1'h0}, 16, rx);
        check(rx[7:0], e);
    endtask
    task automatic fire(input int mx);
        for (int n = 0; n < mx && hoe !== 1'b1; n++) @(posedge clk);
        check(8'(hoe), 8'h01);
    endtask
    task automatic t_regs;
        rd(ADDR_CTRL1, REG_RESET);
        check(8'(oe), 8'h00);
        wr(ADDR_CTRL0, 8'h3c);
        check(c1, 8'h3c);
        wr(ADDR_CTRL2, 8'h81);
        check(c3, 8'h81);
        check(8'(hiz), 8'h00);
        wr(ADDR_CTRL2, 8'h40);
        check(8'(hiz), 8'h01);
        rd(ADDR_CTRL2, 8'h40);
        wr(ADDR_CTRL2, 8'h00);
        check(8'(hiz), 8'h00);
        i_ssw_spi_host.xfer({3'h0, ADDR_CTRL1, 8'h55, 1'h0}, 16, rx);
        check(c2, 8'h00);
        i_ssw_spi_host.xfer({3'h4, ADDR_CTRL1, 8'h3c, 1'h0}, 15, rx);
        check(c2, 8'h00);
        i_ssw_spi_host.xfer({3'h4, ADDR_CTRL1, 8'h3c, 1'h0}, 17, rx);
        check(c2, 8'h00);
        wr(ADDR_STAT0, 8'h7f);
        rd(ADDR_STAT0, 8'h00);
        $display("done regs");
    endtask
    task automatic t_status;
        @(posedge clk) flt <= 6'h07;
        @(posedge clk) flt <= 6'h00;
        repeat (5) @(posedge clk);
        check(8'(fn), 8'h00);
        rd(ADDR_STAT0, 8'h87);
        rd(ADDR_STAT0, 8'h00);
        check(8'(fn), 8'h01);
        $display("done status");
    endtask
    task automatic t_dog;
        wr(ADDR_WDOG, 8'h80);
        repeat (800) @(posedge clk);
        wr(ADDR_WDOG, 8'h80);
        repeat (1150) @(posedge clk);
        check(8'(hoe), 8'h00);
        fire(300);
        check(8'(hn), 8'h00);
        repeat (100) @(posedge clk);
        rd(ADDR_STAT0, 8'hc0);
        wr(ADDR_WDOG, 8'h00);
        rd(ADDR_STAT0, 8'h00);
        wr(ADDR_WDOG, 8'h80);
        wr(ADDR_WDOG, 8'h80);
        fire(200);
        $display("done watchdog");
    endtask
    task automatic t_hard;
        logic seen;
        seen = 1'b0;
        repeat (100) @(posedge clk);
        wr(ADDR_WDOG, 8'h80);
        wr(ADDR_CTRL1, 8'h5a);
        @(posedge clk) hard <= 1'b1;
        repeat (60) @(posedge clk) seen |= hoe;
        hard <= 1'b0;
        repeat (10) @(posedge clk);
        check(c1, 8'h00);
        check(c2, 8'h00);
        rd(ADDR_STAT0, 8'h00);
        repeat (1500) @(posedge clk) seen |= hoe;
        check(8'(seen), 8'h00);
        $display("done hard reset");
    endtask
    task automatic t_sleep;
        logic seen;
        seen = 1'b0;
        wr(ADDR_WDOG, 8'h80);
        repeat (600) @(posedge clk);
        wr(ADDR_CTRL2, 8'h40);
        // a running count would bite inside this window
        repeat (1000) @(posedge clk) seen |= hoe;
        check(8'(seen), 8'h00);
        wr(ADDR_CTRL2, 8'h00);
        repeat (250) @(posedge clk);
        check(8'(hoe), 8'h00);
        fire(650);
        $display("done sleep");
    endtask
    initial begin
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        t_regs();
        t_status();
        t_dog();
        t_hard();
        t_sleep();
        end_of_test();
    end
endmodule
